// *** rtl/acp_axil.sv ***
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes the register file answers hit and data combinationally.
`timescale 1ns/100ps
module acp_axil
   import acp_pkg::*;
#(
   parameter int ADDR_W = ACP_ADDR_W
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output acp_wr_t wr,
   input wire logic wr_hit,
   output logic [ACP_IDX_W-1:0] rd_idx,
   input wire logic [31:0] rd_data,
   input wire logic rd_hit
);

   // ****************************************************************
   // State
   // ****************************************************************
   generate
      if (ADDR_W < ACP_IDX_W + 2)
      begin : g_chk
         $error("acp_axil: ADDR_W too small for the register index");
      end
   endgenerate

   logic aw_held, next_aw_held; // Write address taken
   logic w_held, next_w_held; // Write data taken
   logic [ACP_IDX_W-1:0] aw_idx, next_aw_idx;
   logic [7:0] w_byte, next_w_byte;
   logic w_lane0, next_w_lane0;
   logic [1:0] next_bresp, next_rresp;
   logic next_bvalid, next_rvalid;
   logic [31:0] next_rdata;

   // Readies drop while frozen so no beat is taken and lost
   assign s_axi_awready = ce & ~aw_held;
   assign s_axi_wready = ce & ~w_held;
   assign s_axi_arready = ce & ~s_axi_rvalid;
   assign rd_idx = s_axi_araddr[ACP_IDX_W+1:2];
   assign wr = '{valid: ce & aw_held & w_held & ~s_axi_bvalid,
                 lane0: w_lane0, idx: aw_idx, data: w_byte};

   // Next channel state
   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_idx = aw_idx;
      next_w_byte = w_byte;
      next_w_lane0 = w_lane0;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (s_axi_awvalid & s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_idx = s_axi_awaddr[ACP_IDX_W+1:2];
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_byte = s_axi_wdata[7:0];
         next_w_lane0 = s_axi_wstrb[0];
      end
      // Response follows both halves
      if (wr.valid)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_hit ? ACP_RESP_OKAY : ACP_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready & ce)
      begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rdata = rd_data;
         next_rresp = rd_hit ? ACP_RESP_OKAY : ACP_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready & ce)
      begin
         next_rvalid = 1'b0;
      end
   end

   // Register channel state
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (!reset_n)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ACP_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= ACP_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
         end
         else
         begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_idx <= next_aw_idx;
            w_byte <= next_w_byte;
            w_lane0 <= next_w_lane0;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
         end
      end
   end

endmodule // acp_axil

// *** rtl/acp_mux.sv ***
// Pin function logic for the 8-pin address-capable port and the 3-pin
// control port, with their direction and function-select registers.
// Assumes a 40 MHz clk, synchronous active-low reset_n held for at least
// three enabled edges, and pin pads resolved outside from o/oe.
`timescale 1ns/100ps

module acp_mux
   import acp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [ACP_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ACP_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] operating_select_pins,
   input wire logic [7:0] upper_address_lines,
   input wire logic refresh_request,
   input wire logic [7:0] addr_port_pins_i,
   output logic [7:0] addr_port_pins_o,
   output logic [7:0] addr_port_pins_oe,
   input wire logic [2:0] control_port_pins_i,
   output logic [2:0] control_port_pins_o,
   output logic [2:0] control_port_pins_oe,
   output logic bus_wait,
   output logic ext_fetch_enable
);

   // ****************************************************************
   // Bus front end and pin synchronisers
   // ****************************************************************
   acp_wr_t wr; // Write strobe from the slave
   logic wr_hit; // Write index is mapped
   logic [ACP_IDX_W-1:0] rd_idx; // Read index
   logic [31:0] rd_data; // Read word for rd_idx
   logic rd_hit; // Read index is mapped
   logic [3:0] strap_s; // Synchronised select pins
   logic [7:0] addr_s; // Synchronised address port levels
   logic [2:0] ctl_s; // Synchronised control port levels

   acp_axil #(.ADDR_W(ACP_ADDR_W)) u_axil (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr(wr),
      .wr_hit(wr_hit),
      .rd_idx(rd_idx),
      .rd_data(rd_data),
      .rd_hit(rd_hit)
   );

   // Straps and pad inputs all come from outside the clock domain
   acp_sync #(.WIDTH(15)) u_sync (
      .clk(clk),
      .ce(ce),
      .d({operating_select_pins, control_port_pins_i, addr_port_pins_i}),
      .q({strap_s, ctl_s, addr_s})
   );

   // ****************************************************************
   // Register state
   // ****************************************************************
   acp_mode_t mode, next_mode, strap_mode; // Latched operating mode
   logic [7:0] adir, next_adir; // Address port directions
   logic [2:0] cdir, next_cdir; // Control port directions, bits 7:5
   logic [2:0] fsel, next_fsel; // Function select, bits 7:5
   logic [3:0] mm, next_mm; // Expansion setting bits
   logic [7:0] aout, next_aout; // Address port output latch
   logic [2:0] cout, next_cout; // Control port output latch
   logic next_fetch; // External fetch still possible
   logic [7:0] amask; // Pins carrying address
   logic clk_run; // Clock output divider may toggle
   logic sys_clk_q, next_sys_clk; // Divided clock for the clock pin

   assign strap_mode = acp_mode_of(strap_s);
   assign amask = acp_addr_mask(mm[2:0]);

   // Next register values from bus writes
   always_comb
   begin
      next_mode = mode;
      next_adir = adir;
      next_cdir = cdir;
      next_fsel = fsel;
      next_mm = mm;
      next_aout = aout;
      next_cout = cout;
      next_fetch = ext_fetch_enable;
      if (wr.valid && wr.lane0)
      begin
         case (wr.idx)
            ACP_IDX_ADIR: next_adir = wr.data;
            // Bit index in 2:0, value in bit 3
            ACP_IDX_ABIT: next_adir[wr.data[2:0]] = wr.data[ACP_BIT_VAL];
            // Only bits 7:5 exist; lower bits stay at one
            ACP_IDX_CDIR: next_cdir = wr.data[7:ACP_FN_LSB];
            // Only bits 7:5 exist; lower bits stay at zero
            ACP_IDX_FSEL: next_fsel = wr.data[7:ACP_FN_LSB];
            ACP_IDX_MEXP:
            begin
               next_mm = wr.data[3:0];
               // Once the bus leaves expansion, fetch never returns
               if (wr.data[2:0] == 3'h0)
               begin
                  next_fetch = 1'b0;
               end
            end
            ACP_IDX_AOUT: next_aout = wr.data;
            ACP_IDX_COUT: next_cout = wr.data[7:ACP_FN_LSB];
            default: next_mode = mode;
         endcase
      end
   end

   // Register with mode-dependent reset values
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (!reset_n)
         begin
            // Straps are followed for as long as reset is held
            mode <= strap_mode;
            adir <= ACP_DIR_RST;
            cdir <= ACP_DIR_RST[7:ACP_FN_LSB];
            aout <= ACP_DATA_RST;
            cout <= ACP_DATA_RST[7:ACP_FN_LSB];
            if (strap_mode == ACP_SC0)
            begin
               fsel <= ACP_FSEL_RST_SC0[7:ACP_FN_LSB];
               mm <= ACP_MM_RST_SC0[3:0];
               ext_fetch_enable <= 1'b0;
            end
            else
            begin
               fsel <= ACP_FSEL_RST_CTL[7:ACP_FN_LSB];
               ext_fetch_enable <= 1'b1;
               if (strap_mode == ACP_RL1)
               begin
                  mm <= ACP_MM_RST_HI[3:0];
               end
               else
               begin
                  mm <= ACP_MM_RST_LO[3:0];
               end
            end
         end
         else
         begin
            mode <= next_mode;
            adir <= next_adir;
            cdir <= next_cdir;
            fsel <= next_fsel;
            mm <= next_mm;
            aout <= next_aout;
            cout <= next_cout;
            ext_fetch_enable <= next_fetch;
         end
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   // Write-only registers read as zero; mapped indices answer OKAY
   always_comb
   begin
      rd_hit = 1'b1;
      rd_data = 32'h0000_0000;
      case (rd_idx)
         ACP_IDX_ADIR: rd_data[7:0] = adir;
         ACP_IDX_ABIT: rd_data[7:0] = adir;
         ACP_IDX_CDIR: rd_hit = 1'b1;
         ACP_IDX_FSEL: rd_hit = 1'b1;
         ACP_IDX_MEXP: rd_data[3:0] = mm;
         ACP_IDX_AOUT: rd_data[7:0] = aout;
         // Unimplemented low five bits return zero here
         ACP_IDX_COUT: rd_data[7:ACP_FN_LSB] = cout;
         ACP_IDX_PINS: rd_data[15:0] = {ctl_s, 5'h00, addr_s};
         ACP_IDX_STAT: rd_data[12:0] = {mode, ext_fetch_enable, amask};
         default: rd_hit = 1'b0;
      endcase
   end

   always_comb
   begin
      case (wr.idx)
         ACP_IDX_ADIR, ACP_IDX_ABIT, ACP_IDX_CDIR, ACP_IDX_FSEL,
         ACP_IDX_MEXP, ACP_IDX_AOUT, ACP_IDX_COUT: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // ****************************************************************
   // Pin multiplexing
   // ****************************************************************
   logic [7:0] next_a_o, next_a_oe;
   logic [2:0] next_c_o, next_c_oe;
   logic next_wait;

   // Clock pin runs through reset outside single-chip mode 0
   assign clk_run = !reset_n ? (strap_mode != ACP_SC0) : fsel[2];
   // A flop cannot forward clk itself; half rate is the trade-off
   assign next_sys_clk = clk_run ? ~sys_clk_q : 1'b0;

   // Next pad values for both ports
   always_comb
   begin
      next_a_o = (amask & upper_address_lines) | (~amask & aout);
      next_a_oe = amask | ~adir;
      next_c_o = cout;
      next_c_oe = ~cdir;
      next_wait = 1'b0;
      // Refresh request output on pin five
      if (fsel[0])
      begin
         next_c_o[0] = refresh_request;
         next_c_oe[0] = 1'b1;
      end
      // Wait input on pin six, active low at the pad
      if (fsel[1])
      begin
         next_c_oe[1] = 1'b0;
         next_wait = ~ctl_s[1];
      end
      // Clock output on pin seven
      if (fsel[2])
      begin
         next_c_o[2] = next_sys_clk;
         next_c_oe[2] = 1'b1;
      end
      // All pads float in reset but a running clock pin
      if (!reset_n)
      begin
         next_a_oe = 8'h00;
         next_c_oe = {clk_run, 2'b00};
         next_c_o = {next_sys_clk, 2'b00};
         next_wait = 1'b0;
      end
   end

   // Register pad drivers
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         sys_clk_q <= next_sys_clk;
         addr_port_pins_o <= next_a_o;
         addr_port_pins_oe <= next_a_oe;
         control_port_pins_o <= next_c_o;
         control_port_pins_oe <= next_c_oe;
         bus_wait <= next_wait;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   rst_float_a: assert property (@(posedge clk) disable iff (1'b0)
      (!reset_n && ce) |=> (addr_port_pins_oe == 8'h00))
      else $error("address port drives during reset");
   clk_reset_a: assert property (@(posedge clk) disable iff (1'b0)
      (!reset_n && ce && strap_mode != ACP_SC0)
      |=> control_port_pins_oe[2])
      else $error("clock pin not driven in reset");
   addr_width_a: assert property ((ce && mm[2:0] == 3'h1)
      |=> (addr_port_pins_oe[3:0] == 4'hF) && (addr_port_pins_o[3:0]
      == $past(upper_address_lines[3:0])))
      else $error("low four pins not carrying address");
   dir_reset_a: assert property (($rose(reset_n) && $past(ce))
      |-> (adir == 8'hFF) && (cdir == 3'h7))
      else $error("direction reset value wrong");
   fsel_reset_a: assert property (($rose(reset_n) && $past(ce))
      |-> (fsel == ((mode == ACP_SC0) ? 3'h0 : 3'h7)))
      else $error("function select reset value wrong");
   fetch_kill_a: assert property ((wr.valid && wr.lane0 &&
      wr.idx == ACP_IDX_MEXP && wr.data[2:0] == 3'h0)
      |=> !ext_fetch_enable [*2])
      else $error("fetch still enabled after port mode");
   port_dir_a: assert property ((ce && !fsel[0])
      |=> control_port_pins_oe[0] == !$past(cdir[0]))
      else $error("pin five buffer disagrees with direction");
   fsel_low_a: assert property ((wr.valid && wr.lane0 &&
      wr.idx == ACP_IDX_FSEL && wr.data == 8'h1F)
      |=> fsel == 3'h0)
      else $error("function select low bits not fixed");
   wait_pin_a: assert property ((ce && fsel[1])
      |=> !control_port_pins_oe[1])
      else $error("wait pin driven in control mode");

   cover property (wr.valid && wr.idx == ACP_IDX_MEXP);
   cover property (mode == ACP_SC0 && fsel[2] && control_port_pins_oe[2]);
   cover property (wr.valid && wr.idx == ACP_IDX_ABIT);

endmodule // acp_mux

// *** rtl/acp_pkg.sv ***
// Shared constants, types and decoders for the address and control port
// pin multiplexer.
// Assumes a 32-bit AXI4-Lite register bus and one 40 MHz system clock.
package acp_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int ACP_ADDR_W = 12; // Byte address bits decoded
   localparam int ACP_IDX_W = 10; // Word index bits decoded
   localparam logic [31:0] ACP_FSEL_PRINTED = 32'hFFFFF45A;
   localparam logic [9:0] ACP_IDX_FSEL = ACP_FSEL_PRINTED[9:0];
   localparam logic [9:0] ACP_IDX_ADIR = 10'h000; // Address port dir
   localparam logic [9:0] ACP_IDX_ABIT = 10'h001; // Single-bit dir
   localparam logic [9:0] ACP_IDX_CDIR = 10'h002; // Control port dir
   localparam logic [9:0] ACP_IDX_MEXP = 10'h003; // Expansion setting
   localparam logic [9:0] ACP_IDX_AOUT = 10'h004; // Address port data
   localparam logic [9:0] ACP_IDX_COUT = 10'h005; // Control port data
   localparam logic [9:0] ACP_IDX_PINS = 10'h006; // Pin levels
   localparam logic [9:0] ACP_IDX_STAT = 10'h007; // Block state

   // ****************************************************************
   // Reset values and field positions
   // ****************************************************************
   localparam logic [7:0] ACP_DIR_RST = 8'hFF;
   localparam logic [7:0] ACP_FSEL_RST_SC0 = 8'h00;
   localparam logic [7:0] ACP_FSEL_RST_CTL = 8'hE0;
   localparam logic [7:0] ACP_MM_RST_SC0 = 8'h00;
   localparam logic [7:0] ACP_MM_RST_LO = 8'h07;
   localparam logic [7:0] ACP_MM_RST_HI = 8'h0F;
   localparam logic [7:0] ACP_DATA_RST = 8'h00;
   localparam int ACP_FN_LSB = 5; // Lowest implemented control bit
   localparam int ACP_BIT_VAL = 3; // Value bit of a single-bit write
   localparam logic [1:0] ACP_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACP_RESP_SLVERR = 2'h2;

   // Operating select pin codes
   localparam logic [3:0] ACP_STRAP_RL0 = 4'h0;
   localparam logic [3:0] ACP_STRAP_RL1 = 4'h1;
   localparam logic [3:0] ACP_STRAP_SC1 = 4'h3;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [3:0] {
      ACP_SC0 = 4'b0001,
      ACP_SC1 = 4'b0010,
      ACP_RL0 = 4'b0100,
      ACP_RL1 = 4'b1000
   } acp_mode_t;

   typedef struct packed {
      logic valid; // One-cycle write strobe
      logic lane0; // Byte lane 0 enabled
      logic [ACP_IDX_W-1:0] idx;
      logic [7:0] data;
   } acp_wr_t;

   // Operating mode from the select pins; unknown codes act as mode 0
   function automatic acp_mode_t acp_mode_of(input logic [3:0] s);
      case (s)
         ACP_STRAP_RL0: acp_mode_of = ACP_RL0;
         ACP_STRAP_RL1: acp_mode_of = ACP_RL1;
         ACP_STRAP_SC1: acp_mode_of = ACP_SC1;
         default: acp_mode_of = ACP_SC0;
      endcase
   endfunction

   // Address-carrying pins for the three low expansion bits
   function automatic logic [7:0] acp_addr_mask(input logic [2:0] mm);
      case (mm)
         3'h0: acp_addr_mask = 8'h00;
         3'h1: acp_addr_mask = 8'h0F;
         3'h2: acp_addr_mask = 8'h3F;
         default: acp_addr_mask = 8'hFF;
      endcase
   endfunction

endpackage

// *** rtl/acp_sync.sv ***
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk; flops carry no reset so that
// straps are seen while reset is held.
`timescale 1ns/100ps
module acp_sync
   import acp_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk,
   input wire logic ce,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta; // First stage, read only by q

   // Both stages advance together under the clock enable
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // acp_sync

// *** tb/acp_ext.sv ***
// Far side of the port pins: wait source, wait pin pull-up, wandering undriven pads.
// Assumes the design's o/oe pairs; resolves each pad level for _i.
`timescale 1ns/100ps
module acp_ext
(
   input wire logic clk,
   input wire logic [7:0] addr_port_pins_o,
   input wire logic [7:0] addr_port_pins_oe,
   input wire logic [2:0] control_port_pins_o,
   input wire logic [2:0] control_port_pins_oe,
   input wire logic wait_low,
   output logic [7:0] addr_port_pins_i,
   output logic [2:0] control_port_pins_i
);
   logic [7:0] pat = 8'h5A; // Undriven pads wander, each holding a level four cycles at a time
   // Pattern changes every cycle so a floating pin is never trusted
   always @(posedge clk)
   begin
      pat <= ~{pat[6:0], pat[7]};
   end
   // Driven bits follow the chip, released bits follow the pattern
   assign addr_port_pins_i = (addr_port_pins_oe & addr_port_pins_o) |
                             (~addr_port_pins_oe & pat);
   // Wait pin pulled up; low only while the far side asks to wait
   assign control_port_pins_i = (control_port_pins_oe & control_port_pins_o)
      | (~control_port_pins_oe & {pat[1], ~wait_low, pat[0]});
endmodule // acp_ext

// *** tb/tb_acp_mux.sv ***
// Self-checking bench for the port pin multiplexer, random plus corners.
// Assumes acp_mux answers every bus request before the watchdog ends.
`timescale 1ns/100ps
module tb_acp_mux
   import acp_pkg::*;
;
   logic clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, refresh_request = 0, wait_low = 0;
   logic bus_wait, ext_fetch_enable;
   logic [ACP_ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, r;
   logic [3:0] s_axi_wstrb = 4'hF, operating_select_pins = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] upper_address_lines = 0, d;
   logic [7:0] addr_port_pins_i, addr_port_pins_o, addr_port_pins_oe;
   logic [2:0] control_port_pins_i, control_port_pins_o, control_port_pins_oe;
   int err_count = 0, cmp_count = 0;
   acp_mux u_acp_mux (.clk, .reset_n, .ce(1'b1), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .operating_select_pins, .upper_address_lines, .refresh_request,
      .addr_port_pins_i, .addr_port_pins_o, .addr_port_pins_oe,
      .control_port_pins_i, .control_port_pins_o, .control_port_pins_oe,
      .bus_wait, .ext_fetch_enable);
   acp_ext u_acp_ext (.clk, .addr_port_pins_o, .addr_port_pins_oe,
      .control_port_pins_o, .control_port_pins_oe, .wait_low,
      .addr_port_pins_i, .control_port_pins_i);
   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [7:0] msk(input int m);
      return m == 0 ? 8'h00 : m == 1 ? 8'h0F : m == 2 ? 8'h3F : 8'hFF;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Both halves offered together; each dropped once it is taken
   task automatic wr(input logic [9:0] i, input logic [7:0] v,
                     input logic [1:0] er);
      // One edge passes first so no strobe is assigned twice in a step
      @(posedge clk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'($urandom), v}; // Upper bits must be ignored
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end
      while (s_axi_awvalid | s_axi_wvalid);
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask
   task automatic rd(input logic [9:0] i, output logic [31:0] v);
      // One edge passes first so rready is never set and cleared at once
      @(posedge clk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      v = s_axi_rdata;
      chk(32'(s_axi_rresp), 32'(ACP_RESP_OKAY));
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ****************************************************************
   // Clock, watchdog, main sequence
   // ****************************************************************
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      err_count++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(30));
      // Every strap mode: pins float in reset, clock pin as per mode
      for (int s = 0; s < 4; s++)
      begin
         reset_n <= 0;
         operating_select_pins <= 4'(s);
         repeat (6) @(posedge clk);
         chk(32'({addr_port_pins_oe, control_port_pins_oe}),
             s == 2 ? 0 : 4);
         reset_n <= 1;
         repeat (2) @(posedge clk);
         chk(32'(control_port_pins_oe), s == 2 ? 0 : 5);
         rd(ACP_IDX_MEXP, r);
         chk(r, s == 1 ? 32'hF : s == 2 ? 0 : 7);
         chk(32'(ext_fetch_enable), 32'(s != 2));
      end
      rd(ACP_IDX_ADIR, r);
      chk(r, 32'hFF);
      // Address width walk, widest first so fetch is killed last
      d = 8'($urandom);
      upper_address_lines <= 8'($urandom);
      wr(ACP_IDX_AOUT, d, ACP_RESP_OKAY);
      wr(ACP_IDX_ADIR, 8'h00, ACP_RESP_OKAY);
      for (int m = 3; m >= 0; m--)
      begin
         wr(ACP_IDX_MEXP, 8'(m), ACP_RESP_OKAY);
         repeat (2) @(posedge clk);
         chk(32'({addr_port_pins_oe, addr_port_pins_o}), 32'({8'hFF,
             upper_address_lines & msk(m) | d & ~msk(m)}));
      end
      chk(32'(ext_fetch_enable), 0);
      // Control functions: refresh out, wait in, clock out
      refresh_request <= 1;
      wait_low <= 1;
      repeat (5) @(posedge clk);
      chk(32'({bus_wait, control_port_pins_oe, control_port_pins_o[0]}),
          32'h1B);
      // Clock pin must change level on every edge while selected
      r[0] = control_port_pins_o[2];
      @(posedge clk);
      chk(32'(control_port_pins_o[2] ^ r[0]), 1);
      wait_low <= 0;
      refresh_request <= 0;
      // Low five select bits ignored; control direction taken from bits 7:5 of 0xA0
      wr(ACP_IDX_COUT, 8'h40, ACP_RESP_OKAY);
      wr(ACP_IDX_FSEL, 8'h1F, ACP_RESP_OKAY);
      wr(ACP_IDX_CDIR, 8'hA0, ACP_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(32'({control_port_pins_oe, control_port_pins_o[1]}), 5);
      // Single-bit direction write; an unmapped place is written last
      wr(ACP_IDX_ABIT, 8'h0D, ACP_RESP_OKAY);
      rd(ACP_IDX_ADIR, r);
      chk(r, 32'h20);
      chk(32'(addr_port_pins_oe), 32'hDF);
      // Low byte lane off: write answers OKAY but changes nothing
      s_axi_wstrb <= 4'h0;
      wr(ACP_IDX_ADIR, 8'hFF, ACP_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(ACP_IDX_ADIR, r);
      chk(r, 32'h20);
      // Driven pads read back through the synchronisers
      rd(ACP_IDX_PINS, r);
      chk(r & 32'h40DF, 32'h4000 | 32'(d & 8'hDF));
      wr(10'h3FF, 8'h00, ACP_RESP_SLVERR);
      end_of_test();
   end
endmodule // tb_acp_mux
